// >>> common/ovsa_pkg.sv
/*
 * Package for the overlay surface address register bank: register offsets,
 * field positions, reset values and the packed types carried between blocks.
 * Assumes a byte-addressed register space with one 32-bit word per register.
 */
package ovsa_pkg;

    // ========================================================================
    // Register space
    // ========================================================================
    localparam int unsigned ADDR_W = 20;
    localparam logic [19:0] OFS_CMD = 20'h0_0068;
    localparam logic [19:0] OFS_LUMA_BUF0_BASE_ADDR = 20'h0_0070;
    localparam logic [19:0] OFS_LUMA_BUF1_BASE_ADDR = 20'h0_0074;
    localparam logic [19:0] OFS_CHROMA_U_BUF0_BASE_ADDR = 20'h0_0078;
    localparam logic [19:0] OFS_CHROMA_V_BUF0_BASE_ADDR = 20'h0_007C;
    localparam logic [19:0] OFS_CHROMA_U_BUF1_BASE_ADDR = 20'h0_0080;
    localparam logic [19:0] OFS_CHROMA_V_BUF1_BASE_ADDR = 20'h0_0084;
    localparam logic [19:0] OFS_LUMA_BUF0_TILE_START = 20'h0_0088;
    localparam logic [19:0] OFS_LUMA_BUF1_TILE_START = 20'h0_008C;
    localparam logic [19:0] OFS_CHROMA_U_BUF0_TILE_START = 20'h0_0090;
    localparam logic [19:0] OFS_DEBUG_MIRROR = 20'h3_0100;
    localparam int unsigned N_BASE = 6;
    localparam int unsigned N_TILE = 3;

    // Index of each base address register within the bank.
    localparam int unsigned IDX_LUMA0 = 0;
    localparam int unsigned IDX_LUMA1 = 1;
    localparam int unsigned IDX_U0 = 2;
    localparam int unsigned IDX_V0 = 3;
    localparam int unsigned IDX_U1 = 4;
    localparam int unsigned IDX_V1 = 5;

    // ========================================================================
    // Field layout
    // ========================================================================
    localparam int unsigned CMD_TILED_BIT = 19;
    localparam int unsigned CMD_MIRROR_LSB = 17;
    localparam int unsigned CMD_ACTIVE_BUFFER_POINTER_LSB = 2;
    localparam int unsigned TILE_Y_LSB = 16;
    localparam int unsigned TILE_X_LSB = 0;
    localparam int unsigned POS_W = 12;
    localparam logic [31:0] BASE_PAGE_MASK = 32'hFFFF_F000;
    localparam logic [31:0] TILE_FIELD_MASK = 32'h0FFF_0FFF;
    localparam logic [31:0] CMD_FIELD_MASK = 32'h000E_000C;
    localparam logic [31:0] RESET_VALUE = 32'h0000_0000;
    localparam logic [1:0] ACTIVE_BUFFER_POINTER_SET0 = 2'h0;
    localparam logic [1:0] ACTIVE_BUFFER_POINTER_SET1 = 2'h1;

    typedef enum logic [1:0] {
        OVSA_MIR_NONE = 2'h0,
        OVSA_MIR_H = 2'h1,
        OVSA_MIR_V = 2'h2,
        OVSA_MIR_BOTH = 2'h3
    } ovsa_mirror_type;

    typedef struct packed {
        logic tiled;
        logic [1:0] mirror;
        logic [1:0] active_buffer_pointer;
    } ovsa_cmd_type;

    typedef struct packed {
        logic [11:0] y;
        logic [11:0] x;
    } ovsa_tile_pos_type;

endpackage

// >>> rtl/ovsa_tile_pos.sv
/*
 * Start position interpreter for one tiled plane. Registers the x,y start
 * fields for the fetch engine and flags how mirroring changes their meaning.
 * Assumes the tiled and mirror settings come from logic on the same clock.
 */
`timescale 1ns/10ps

module ovsa_tile_pos (
    input wire logic clk, // Register clock.
    input wire logic rst, // Synchronous reset, active high.
    input wire ovsa_pkg::ovsa_tile_pos_type raw, // Stored start fields.
    input wire logic avail, // A start register exists for this plane.
    input wire logic tiled, // Surface layout is X-tiled.
    input wire logic [1:0] mirror, // Mirroring mode.
    output ovsa_pkg::ovsa_tile_pos_type pos, // Start position used.
    output logic valid, // Position applies to the fetch.
    output logic x_last, // X names the last pixel of the line.
    output logic y_from_end // Y is the lower right corner from the data end.
);

    ovsa_pkg::ovsa_tile_pos_type pos_q;
    logic valid_q;
    logic x_last_q;
    logic y_from_end_q;
    logic use_pos;

    assign use_pos = tiled && avail;

    // ========================================================================
    // Position and meaning
    // ========================================================================
    // A linear surface pans by linear offset, so the start fields read as zero.
    always_ff @(posedge clk) begin
        if (rst) begin
            pos_q <= '0;
            valid_q <= 1'b0;
        end else begin
            pos_q.y <= use_pos ? raw.y : '0;
            pos_q.x <= use_pos ? raw.x : '0;
            valid_q <= use_pos;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            x_last_q <= 1'b0;
            y_from_end_q <= 1'b0;
        end else begin
            x_last_q <= use_pos && mirror[0];
            y_from_end_q <= use_pos && mirror[1];
        end
    end

    assign pos = pos_q;
    assign valid = valid_q;
    assign x_last = x_last_q;
    assign y_from_end = y_from_end_q;

    // ========================================================================
    // Checks
    // ========================================================================
    AST_X_FIELD: assert property (@(posedge clk) disable iff (rst)
        (tiled && avail) |=> (pos.x == $past(raw.x)) && valid)
        else $error("x start does not follow the stored field");

    AST_Y_FIELD: assert property (@(posedge clk) disable iff (rst)
        (tiled && avail) |=> (pos.y == $past(raw.y)))
        else $error("y start does not follow the stored field");

    AST_LINEAR_IGNORED: assert property (@(posedge clk) disable iff (rst)
        !tiled |=> !valid && (pos == '0))
        else $error("start position used on a linear surface");

    AST_MIRROR_H: assert property (@(posedge clk) disable iff (rst)
        (tiled && avail && mirror[0]) |=> x_last)
        else $error("horizontal mirror not flagged on x start");

    AST_MIRROR_V: assert property (@(posedge clk) disable iff (rst)
        (tiled && avail) |=> (y_from_end == $past(mirror[1])))
        else $error("vertical mirror meaning of y start wrong");

endmodule

// >>> rtl/ovsa_top.sv
/*
 * Overlay surface address register bank: command layout fields, six plane
 * base addresses and three tiled start registers, with the read-only debug
 * mirror space, and the registered address set handed to the fetch engine.
 * Assumes one register clock, single-cycle read and write strobes from the
 * register space decoder, and a fetch engine that translates aperture
 * offsets through the global translation table.
 */
`timescale 1ns/10ps

module ovsa_top (
    input wire logic CLK, // Register clock, 10 MHz.
    input wire logic SYS_RST, // Synchronous reset, active high.
    input wire logic [19:0] REG_ADDR, // Byte address of the access.
    input wire logic REG_WR, // Write strobe, one cycle.
    input wire logic [31:0] REG_WDATA, // Write data.
    input wire logic REG_RD, // Read strobe, one cycle.
    output logic [31:0] REG_RDATA, // Read data, held until the next read.
    output logic REG_RVALID, // Read data valid, one cycle.
    output logic [31:0] FETCH_LUMA_BASE, // Luma base of the active set.
    output logic [31:0] FETCH_U_BASE, // Chroma U base of the active set.
    output logic [31:0] FETCH_V_BASE, // Chroma V base of the active set.
    output logic FETCH_BUF_SEL, // Active buffer set.
    output logic FETCH_TILED, // Surfaces are X-tiled.
    output logic FETCH_LINEAR_PAN, // Pan by linear buffer offset.
    output logic [1:0] FETCH_MIRROR, // Mirroring mode.
    output ovsa_pkg::ovsa_tile_pos_type FETCH_LUMA_POS, // Luma start x,y.
    output logic FETCH_LUMA_POS_VALID, // Luma start applies.
    output logic FETCH_LUMA_X_LAST, // Luma x names the last pixel.
    output logic FETCH_LUMA_Y_FROM_END, // Luma y counts from the data end.
    output ovsa_pkg::ovsa_tile_pos_type FETCH_U_POS, // Chroma U start x,y.
    output logic FETCH_U_POS_VALID, // Chroma U start applies.
    output logic FETCH_U_X_LAST, // Chroma U x names the last pixel.
    output logic FETCH_U_Y_FROM_END // Chroma U y counts from the data end.
);

    ovsa_pkg::ovsa_cmd_type cmd_q;
    logic [31:0] base_q [ovsa_pkg::N_BASE];
    ovsa_pkg::ovsa_tile_pos_type tile_q [ovsa_pkg::N_TILE];
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic rvalid_q;
    logic [31:0] luma_base_q;
    logic [31:0] u_base_q;
    logic [31:0] v_base_q;
    logic buf_sel_q;
    logic tiled_q;
    logic [1:0] mirror_q;
    logic wr_cmd;
    logic [1:0] new_buf;
    logic sel;

    assign wr_cmd = REG_WR && (REG_ADDR == ovsa_pkg::OFS_CMD);
    assign new_buf = REG_WDATA[ovsa_pkg::CMD_ACTIVE_BUFFER_POINTER_LSB +: 2];
    assign sel = cmd_q.active_buffer_pointer[0];

    // ========================================================================
    // Command layout fields
    // ========================================================================
    // A reserved buffer code leaves the previous selection in place, so the
    // fetch engine never sees a set that does not exist.
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            cmd_q <= '0;
        end else if (wr_cmd) begin
            cmd_q.tiled <= REG_WDATA[ovsa_pkg::CMD_TILED_BIT];
            cmd_q.mirror <= REG_WDATA[ovsa_pkg::CMD_MIRROR_LSB +: 2];
            if (new_buf == ovsa_pkg::ACTIVE_BUFFER_POINTER_SET0 || new_buf == ovsa_pkg::ACTIVE_BUFFER_POINTER_SET1) begin
                cmd_q.active_buffer_pointer <= new_buf;
            end
        end
    end

    // ========================================================================
    // Base address and tiled start storage
    // ========================================================================
    // Writes land only at the primary offsets; the debug mirror is read-only.
    generate
        for (genvar i = 0; i < ovsa_pkg::N_BASE; i++) begin : g_base
            always_ff @(posedge CLK) begin
                if (SYS_RST) begin
                    base_q[i] <= ovsa_pkg::RESET_VALUE;
                end else if (REG_WR && REG_ADDR ==
                        ovsa_pkg::OFS_LUMA_BUF0_BASE_ADDR + 20'(4 * i)) begin
                    base_q[i] <= REG_WDATA;
                end
            end
        end
        for (genvar t = 0; t < ovsa_pkg::N_TILE; t++) begin : g_tile
            always_ff @(posedge CLK) begin
                if (SYS_RST) begin
                    tile_q[t] <= '0;
                end else if (REG_WR && REG_ADDR ==
                        ovsa_pkg::OFS_LUMA_BUF0_TILE_START + 20'(4 * t)) begin
                    tile_q[t].y <= REG_WDATA[ovsa_pkg::TILE_Y_LSB +: ovsa_pkg::POS_W];
                    tile_q[t].x <= REG_WDATA[ovsa_pkg::TILE_X_LSB +: ovsa_pkg::POS_W];
                end
            end
        end
    endgenerate

    // ========================================================================
    // Register reads
    // ========================================================================
    // Reserved bits are not stored, so they always read as zero whatever
    // software wrote into them.
    always_comb begin
        rdata_d = '0;
        if (REG_ADDR == ovsa_pkg::OFS_CMD ||
                REG_ADDR == ovsa_pkg::OFS_CMD + ovsa_pkg::OFS_DEBUG_MIRROR) begin
            rdata_d[ovsa_pkg::CMD_TILED_BIT] = cmd_q.tiled;
            rdata_d[ovsa_pkg::CMD_MIRROR_LSB +: 2] = cmd_q.mirror;
            rdata_d[ovsa_pkg::CMD_ACTIVE_BUFFER_POINTER_LSB +: 2] = cmd_q.active_buffer_pointer;
        end
        for (int i = 0; i < ovsa_pkg::N_BASE; i++) begin
            if (REG_ADDR == ovsa_pkg::OFS_LUMA_BUF0_BASE_ADDR + 20'(4 * i)) begin
                rdata_d = base_q[i];
            end
        end
        for (int t = 0; t < ovsa_pkg::N_TILE; t++) begin
            if (REG_ADDR == ovsa_pkg::OFS_LUMA_BUF0_TILE_START + 20'(4 * t) ||
                    REG_ADDR == ovsa_pkg::OFS_LUMA_BUF0_TILE_START +
                    ovsa_pkg::OFS_DEBUG_MIRROR + 20'(4 * t)) begin
                rdata_d = {4'h0, tile_q[t].y, 4'h0, tile_q[t].x};
            end
        end
        // Base mirrors fall through to zero: no debug readback path.
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            rdata_q <= '0;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= REG_RD;
            if (REG_RD) begin
                rdata_q <= rdata_d;
            end
        end
    end

    assign REG_RDATA = rdata_q;
    assign REG_RVALID = rvalid_q;

    // ========================================================================
    // Fetch address set
    // ========================================================================
    // The bases leave as aperture offsets; page translation belongs to the
    // fetch path. Masking the page offset costs nothing and keeps a careless
    // write from producing an unaligned fetch.
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            luma_base_q <= '0;
            u_base_q <= '0;
            v_base_q <= '0;
            buf_sel_q <= 1'b0;
        end else begin
            luma_base_q <= (sel ? base_q[ovsa_pkg::IDX_LUMA1] : base_q[ovsa_pkg::IDX_LUMA0])
                & ovsa_pkg::BASE_PAGE_MASK;
            u_base_q <= (sel ? base_q[ovsa_pkg::IDX_U1] : base_q[ovsa_pkg::IDX_U0])
                & ovsa_pkg::BASE_PAGE_MASK;
            v_base_q <= (sel ? base_q[ovsa_pkg::IDX_V1] : base_q[ovsa_pkg::IDX_V0])
                & ovsa_pkg::BASE_PAGE_MASK;
            buf_sel_q <= sel;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            tiled_q <= 1'b0;
            mirror_q <= ovsa_pkg::OVSA_MIR_NONE;
        end else begin
            tiled_q <= cmd_q.tiled;
            mirror_q <= cmd_q.mirror;
        end
    end

    assign FETCH_LUMA_BASE = luma_base_q;
    assign FETCH_U_BASE = u_base_q;
    assign FETCH_V_BASE = v_base_q;
    assign FETCH_BUF_SEL = buf_sel_q;
    assign FETCH_TILED = tiled_q;
    assign FETCH_LINEAR_PAN = !tiled_q;
    assign FETCH_MIRROR = mirror_q;

    // Chroma U has a start register for set 0 only; in set 1 it reads invalid.
    ovsa_tile_pos u_luma_pos (
        .clk(CLK),
        .rst(SYS_RST),
        .raw(sel ? tile_q[1] : tile_q[0]),
        .avail(1'b1),
        .tiled(cmd_q.tiled),
        .mirror(cmd_q.mirror),
        .pos(FETCH_LUMA_POS),
        .valid(FETCH_LUMA_POS_VALID),
        .x_last(FETCH_LUMA_X_LAST),
        .y_from_end(FETCH_LUMA_Y_FROM_END)
    );

    ovsa_tile_pos u_chroma_pos (
        .clk(CLK),
        .rst(SYS_RST),
        .raw(tile_q[2]),
        .avail(!sel),
        .tiled(cmd_q.tiled),
        .mirror(cmd_q.mirror),
        .pos(FETCH_U_POS),
        .valid(FETCH_U_POS_VALID),
        .x_last(FETCH_U_X_LAST),
        .y_from_end(FETCH_U_Y_FROM_END)
    );

    // ========================================================================
    // Checks
    // ========================================================================
    AST_BASE_ALIGN: assert property (@(posedge CLK) disable iff (SYS_RST)
        (FETCH_LUMA_BASE[11:0] == 12'h000) && (FETCH_U_BASE[11:0] == 12'h000)
        && (FETCH_V_BASE[11:0] == 12'h000))
        else $error("fetch base not page aligned");

    AST_BASE_SELECT: assert property (@(posedge CLK) disable iff (SYS_RST)
        ##1 FETCH_LUMA_BASE == (($past(sel) ? $past(base_q[1]) : $past(base_q[0]))
        & ovsa_pkg::BASE_PAGE_MASK))
        else $error("luma base does not follow the active set");

    AST_DEBUG_BASE_ZERO: assert property (@(posedge CLK) disable iff (SYS_RST)
        (REG_RD && REG_ADDR >= ovsa_pkg::OFS_LUMA_BUF0_BASE_ADDR + ovsa_pkg::OFS_DEBUG_MIRROR
        && REG_ADDR <= ovsa_pkg::OFS_CHROMA_V_BUF1_BASE_ADDR + ovsa_pkg::OFS_DEBUG_MIRROR)
        |=> REG_RVALID && (REG_RDATA == 32'h0000_0000))
        else $error("base register visible on the debug path");

    AST_TILE_MIRROR: assert property (@(posedge CLK) disable iff (SYS_RST)
        (REG_WR && REG_ADDR == ovsa_pkg::OFS_LUMA_BUF0_TILE_START) ##1
        (REG_RD && !REG_WR && REG_ADDR ==
        ovsa_pkg::OFS_LUMA_BUF0_TILE_START + ovsa_pkg::OFS_DEBUG_MIRROR)
        |=> REG_RDATA == ($past(REG_WDATA, 2) & ovsa_pkg::TILE_FIELD_MASK))
        else $error("tiled start debug mirror does not match");

    AST_LINEAR_PAN: assert property (@(posedge CLK) disable iff (SYS_RST)
        FETCH_LINEAR_PAN |-> !FETCH_LUMA_POS_VALID && !FETCH_U_POS_VALID)
        else $error("x,y start used while panning linearly");

    AST_TILED_SELECT: assert property (@(posedge CLK) disable iff (SYS_RST)
        wr_cmd ##1 !wr_cmd |=> FETCH_TILED == $past(REG_WDATA[19], 2))
        else $error("layout select not taken from command bit");

    AST_MIRROR_SELECT: assert property (@(posedge CLK) disable iff (SYS_RST)
        wr_cmd ##1 !wr_cmd |=> FETCH_MIRROR == $past(REG_WDATA[18:17], 2))
        else $error("mirroring mode not taken from command field");

    AST_RESERVED_BUF: assert property (@(posedge CLK) disable iff (SYS_RST)
        (wr_cmd && REG_WDATA[3]) |=> cmd_q.active_buffer_pointer == $past(cmd_q.active_buffer_pointer))
        else $error("reserved buffer code was accepted");

    AST_RESET_ZERO: assert property (@(posedge CLK)
        SYS_RST |=> (tile_q[0] == '0) && (tile_q[1] == '0) && (tile_q[2] == '0))
        else $error("tiled start register not zero after reset");

    // The leading one-edge delay starts each check after reset has gone, so
    // that the history these checks look back on never lies inside reset.
    AST_U_BASE_SELECT: assert property (@(posedge CLK) disable iff (SYS_RST)
        ##1 FETCH_U_BASE == (($past(sel) ? $past(base_q[ovsa_pkg::IDX_U1])
        : $past(base_q[ovsa_pkg::IDX_U0])) & ovsa_pkg::BASE_PAGE_MASK))
        else $error("chroma U base does not follow the active set");

    AST_V_BASE_SELECT: assert property (@(posedge CLK) disable iff (SYS_RST)
        ##1 FETCH_V_BASE == (($past(sel) ? $past(base_q[ovsa_pkg::IDX_V1])
        : $past(base_q[ovsa_pkg::IDX_V0])) & ovsa_pkg::BASE_PAGE_MASK))
        else $error("chroma V base does not follow the active set");

    AST_BUF_SEL_OUT: assert property (@(posedge CLK) disable iff (SYS_RST)
        ##1 FETCH_BUF_SEL == $past(sel))
        else $error("buffer select does not follow the active pointer");

    AST_ACTIVE_BUFFER_POINTER_LEGAL: assert property (@(posedge CLK) disable iff (SYS_RST)
        cmd_q.active_buffer_pointer[1] == 1'b0)
        else $error("reserved buffer code held in the command register");

    AST_READ_VALID: assert property (@(posedge CLK) disable iff (SYS_RST)
        ##1 REG_RVALID == $past(REG_RD))
        else $error("read valid does not follow the read strobe");

    AST_MIRROR_READ_ONLY: assert property (@(posedge CLK) disable iff (SYS_RST)
        (REG_WR && REG_ADDR == ovsa_pkg::OFS_LUMA_BUF0_TILE_START + ovsa_pkg::OFS_DEBUG_MIRROR)
        |=> tile_q[0] == $past(tile_q[0]))
        else $error("debug mirror write changed a tiled start register");

endmodule

// >>> tb/ovsa_top_test.sv
/*
 * Self-checking testbench for the overlay surface address register bank.
 * Assumes the bank answers reads one cycle after the strobe edge and that the
 * fetch outputs settle two edges after the write that changes them.
 */
`timescale 1ns/10ps

module ovsa_top_test;
    logic CLK = 1'b0;
    logic SYS_RST = 1'b1;
    logic [19:0] REG_ADDR = 20'h0_0000;
    logic REG_WR = 1'b0;
    logic [31:0] REG_WDATA = 32'h0000_0000;
    logic REG_RD = 1'b0;
    logic [31:0] REG_RDATA, FETCH_LUMA_BASE, FETCH_U_BASE, FETCH_V_BASE;
    logic REG_RVALID, FETCH_BUF_SEL, FETCH_TILED, FETCH_LINEAR_PAN;
    logic [1:0] FETCH_MIRROR;
    ovsa_pkg::ovsa_tile_pos_type FETCH_LUMA_POS, FETCH_U_POS;
    logic FETCH_LUMA_POS_VALID, FETCH_LUMA_X_LAST, FETCH_LUMA_Y_FROM_END;
    logic FETCH_U_POS_VALID, FETCH_U_X_LAST, FETCH_U_Y_FROM_END;
    int errors = 0;
    int comparisons = 0;
    logic [31:0] bval [6];

    ovsa_top uut (
        .CLK(CLK), .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
        .REG_WDATA(REG_WDATA), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
        .REG_RVALID(REG_RVALID), .FETCH_LUMA_BASE(FETCH_LUMA_BASE),
        .FETCH_U_BASE(FETCH_U_BASE), .FETCH_V_BASE(FETCH_V_BASE),
        .FETCH_BUF_SEL(FETCH_BUF_SEL), .FETCH_TILED(FETCH_TILED),
        .FETCH_LINEAR_PAN(FETCH_LINEAR_PAN), .FETCH_MIRROR(FETCH_MIRROR),
        .FETCH_LUMA_POS(FETCH_LUMA_POS), .FETCH_LUMA_POS_VALID(FETCH_LUMA_POS_VALID),
        .FETCH_LUMA_X_LAST(FETCH_LUMA_X_LAST), .FETCH_LUMA_Y_FROM_END(FETCH_LUMA_Y_FROM_END),
        .FETCH_U_POS(FETCH_U_POS), .FETCH_U_POS_VALID(FETCH_U_POS_VALID),
        .FETCH_U_X_LAST(FETCH_U_X_LAST), .FETCH_U_Y_FROM_END(FETCH_U_Y_FROM_END)
    );

    // ========================================================================
    // Clock and shared tasks
    // ========================================================================
    initial begin
        forever #50 CLK = ~CLK;
    end

    task automatic conclude();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [19:0] a, input logic [31:0] d);
        @(negedge CLK);
        REG_WR = 1'b1;
        REG_ADDR = a;
        REG_WDATA = d;
        @(negedge CLK);
        REG_WR = 1'b0;
    endtask

    // Reads wait a bounded number of cycles so a dead valid cannot hang the run.
    task automatic rchk(input logic [19:0] a, input logic [31:0] exp);
        int n;
        @(negedge CLK);
        REG_RD = 1'b1;
        REG_ADDR = a;
        @(negedge CLK);
        REG_RD = 1'b0;
        n = 0;
        while (REG_RVALID !== 1'b1 && n < 8) begin
            @(negedge CLK);
            n++;
        end
        if (n == 8) begin
            errors++;
            $display("ERROR read valid expected 1 seen 0");
            conclude();
        end else begin
            check($sformatf("read %h", a), REG_RDATA, exp);
        end
    endtask

    // Sets tiled, mirror and buffer fields, then lets the fetch outputs settle.
    task automatic cmd(input logic t, input logic [1:0] m, input logic [1:0] b);
        wr(ovsa_pkg::OFS_CMD, {12'h000, t, m, 13'h0000, b, 2'h0});
        repeat (2) @(negedge CLK);
    endtask

    // ========================================================================
    // Scenarios
    // ========================================================================
    task automatic test_reset();
        for (int i = 0; i < 9; i++) begin
            rchk(20'h0_0070 + 20'(4 * i), 32'h0000_0000);
        end
        rchk(20'h3_0188, 32'h0000_0000);
        check("linear pan", {31'h0, FETCH_LINEAR_PAN}, 32'h0000_0001);
        check("luma base", FETCH_LUMA_BASE, 32'h0000_0000);
        $display("test reset done");
    endtask

    task automatic test_bases();
        for (int i = 0; i < 6; i++) begin
            bval[i] = 32'h1357_0000 + 32'h0011_1000 * (i + 1);
            wr(20'h0_0070 + 20'(4 * i), bval[i]);
        end
        for (int i = 0; i < 6; i++) begin
            rchk(20'h0_0070 + 20'(4 * i), bval[i]);
            rchk(20'h3_0170 + 20'(4 * i), 32'h0000_0000);
        end
        cmd(1'b0, 2'h0, ovsa_pkg::ACTIVE_BUFFER_POINTER_SET1);
        check("buf sel", {31'h0, FETCH_BUF_SEL}, 32'h0000_0001);
        check("luma1", FETCH_LUMA_BASE, bval[1] & ovsa_pkg::BASE_PAGE_MASK);
        check("u1", FETCH_U_BASE, bval[4] & ovsa_pkg::BASE_PAGE_MASK);
        check("v1", FETCH_V_BASE, bval[5] & ovsa_pkg::BASE_PAGE_MASK);
        cmd(1'b0, 2'h0, 2'h3);
        check("reserved buf", {31'h0, FETCH_BUF_SEL}, 32'h0000_0001);
        cmd(1'b0, 2'h0, 2'h2);
        check("reserved buf", {31'h0, FETCH_BUF_SEL}, 32'h0000_0001);
        rchk(ovsa_pkg::OFS_CMD, 32'h0000_0004);
        cmd(1'b0, 2'h0, ovsa_pkg::ACTIVE_BUFFER_POINTER_SET0);
        check("buf sel", {31'h0, FETCH_BUF_SEL}, 32'h0000_0000);
        check("luma0", FETCH_LUMA_BASE, bval[0] & ovsa_pkg::BASE_PAGE_MASK);
        check("u0", FETCH_U_BASE, bval[2] & ovsa_pkg::BASE_PAGE_MASK);
        check("v0", FETCH_V_BASE, bval[3] & ovsa_pkg::BASE_PAGE_MASK);
        // One deliberately misaligned write: the fetch side must still see a page base.
        wr(ovsa_pkg::OFS_LUMA_BUF0_BASE_ADDR, bval[0] | 32'h0000_0ABC);
        repeat (2) @(negedge CLK);
        check("luma0 masked", FETCH_LUMA_BASE, bval[0]);
        rchk(ovsa_pkg::OFS_LUMA_BUF0_BASE_ADDR, bval[0] | 32'h0000_0ABC);
        $display("test bases done");
    endtask

    task automatic test_tiles();
        // The luma set 0 write sets reserved bits on purpose; they must not be stored.
        wr(ovsa_pkg::OFS_LUMA_BUF0_TILE_START, 32'hF321_F654);
        wr(ovsa_pkg::OFS_LUMA_BUF1_TILE_START, 32'h0ABC_0123);
        wr(ovsa_pkg::OFS_CHROMA_U_BUF0_TILE_START, 32'h0765_0432);
        wr(20'h3_0188, 32'h0000_0000);
        wr(20'h0_00A0, 32'hFFFF_FFFF);
        rchk(20'h0_0088, 32'h0321_0654);
        rchk(20'h3_0188, 32'h0321_0654);
        rchk(20'h3_018C, 32'h0ABC_0123);
        rchk(20'h3_0190, 32'h0765_0432);
        rchk(20'h0_00A0, 32'h0000_0000);
        cmd(1'b0, 2'h3, ovsa_pkg::ACTIVE_BUFFER_POINTER_SET0);
        check("linear valid", {31'h0, FETCH_LUMA_POS_VALID}, 32'h0000_0000);
        check("linear pos", {8'h00, FETCH_LUMA_POS}, 32'h0000_0000);
        check("linear pan", {31'h0, FETCH_LINEAR_PAN}, 32'h0000_0001);
        check("linear xlast", {31'h0, FETCH_LUMA_X_LAST}, 32'h0000_0000);
        for (int m = 0; m < 4; m++) begin
            cmd(1'b1, 2'(m), ovsa_pkg::ACTIVE_BUFFER_POINTER_SET0);
            rchk(20'h3_0168, {12'h000, 1'b1, 2'(m), 17'h0_0000});
            check("luma valid", {31'h0, FETCH_LUMA_POS_VALID}, 32'h0000_0001);
            check("tiled", {31'h0, FETCH_TILED}, 32'h0000_0001);
            check("pan", {31'h0, FETCH_LINEAR_PAN}, 32'h0000_0000);
            check("mirror", {30'h0, FETCH_MIRROR}, 32'(m));
            check("luma pos", {8'h00, FETCH_LUMA_POS}, 32'h0032_1654);
            check("u pos", {8'h00, FETCH_U_POS}, 32'h0076_5432);
            check("u valid", {31'h0, FETCH_U_POS_VALID}, 32'h0000_0001);
            check("x last", {31'h0, FETCH_LUMA_X_LAST}, 32'(m % 2));
            check("y end", {31'h0, FETCH_LUMA_Y_FROM_END}, 32'(m / 2));
            check("u x last", {31'h0, FETCH_U_X_LAST}, 32'(m % 2));
            check("u y end", {31'h0, FETCH_U_Y_FROM_END}, 32'(m / 2));
        end
        cmd(1'b1, 2'h0, ovsa_pkg::ACTIVE_BUFFER_POINTER_SET1);
        check("luma1 pos", {8'h00, FETCH_LUMA_POS}, 32'h00AB_C123);
        check("u1 valid", {31'h0, FETCH_U_POS_VALID}, 32'h0000_0000);
        check("u1 pos", {8'h00, FETCH_U_POS}, 32'h0000_0000);
        // Write, then read the debug mirror in the very next cycle.
        @(negedge CLK);
        REG_WR = 1'b1;
        REG_ADDR = ovsa_pkg::OFS_LUMA_BUF0_TILE_START;
        REG_WDATA = 32'h0456_0789;
        @(negedge CLK);
        REG_WR = 1'b0;
        REG_RD = 1'b1;
        REG_ADDR = 20'h3_0188;
        @(negedge CLK);
        REG_RD = 1'b0;
        check("b2b valid", {31'h0, REG_RVALID}, 32'h0000_0001);
        check("b2b read", REG_RDATA, 32'h0456_0789);
        $display("test tiles done");
    endtask

    task automatic test_midrun_reset();
        @(negedge CLK);
        SYS_RST = 1'b1;
        repeat (2) @(negedge CLK);
        SYS_RST = 1'b0;
        @(negedge CLK);
        rchk(ovsa_pkg::OFS_LUMA_BUF0_TILE_START, 32'h0000_0000);
        check("reset tiled", {31'h0, FETCH_TILED}, 32'h0000_0000);
        check("reset pos", {8'h00, FETCH_LUMA_POS}, 32'h0000_0000);
        check("reset buf sel", {31'h0, FETCH_BUF_SEL}, 32'h0000_0000);
        $display("test midrun reset done");
    endtask

    // ========================================================================
    // Main sequence
    // ========================================================================
    initial begin
        repeat (8) @(negedge CLK);
        SYS_RST = 1'b0;
        @(negedge CLK);
        test_reset();
        test_bases();
        test_tiles();
        test_midrun_reset();
        conclude();
    end
endmodule
